// File: mixer_pkg.sv
// Purpose: Shared constants and carrier types for the audio routing matrix.
// Assumes: 24-bit signed samples, 16-bit Q1.15 gains, 32-bit AHB-Lite data.
// Notes: All byte offsets are relative to the slave's 8 KiB window.
package mixer_pkg;
  // ----------------------------------------------------------------
  // Channel counts
  // ----------------------------------------------------------------
  localparam int N_IN = 10;
  localparam int N_PB = 12;
  localparam int N_SRC = N_IN + N_PB;
  localparam int N_OUT = 12;
  localparam int N_MTR = N_SRC + N_OUT;
  localparam int SW = 24;
  localparam int GW = 16;
  localparam int RMS_SHIFT = 10;
  localparam int FIFO_DEPTH = 4;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [12:0] A_MODE = 13'h0000;
  localparam logic [12:0] A_STEREO = 13'h0004;
  localparam logic [12:0] A_MUTE = 13'h0008;
  localparam logic [12:0] A_SOLO = 13'h000C;
  localparam logic [12:0] A_TRIM_EN = 13'h0010;
  localparam logic [12:0] A_LOOP = 13'h0014;
  localparam logic [12:0] A_HOLD = 13'h0018;
  localparam logic [12:0] A_OVER = 13'h001C;
  localparam logic [12:0] A_RMS_REF = 13'h0020;
  localparam logic [12:0] A_STATUS = 13'h0024;
  localparam logic [12:0] A_PAN_BASE = 13'h0100;
  localparam logic [12:0] A_TRIM_BASE = 13'h0200;
  localparam logic [12:0] A_METER_BASE = 13'h0800;
  localparam logic [12:0] A_GAIN_BASE = 13'h1000;
  // ----------------------------------------------------------------
  // Reset values and field constants
  // ----------------------------------------------------------------
  localparam logic [15:0] GAIN_UNITY = 16'h8000;
  localparam logic [15:0] HOLD_RST = 16'h4000;
  localparam logic [3:0] OVER_RST = 4'h3;
  localparam logic [31:0] RMS_REF_RST = 32'h0010_0000;
  localparam logic [3:0] PAN_CENTRE = 4'h4;
  localparam logic [3:0] PAN_MAX = 4'h8;
  localparam logic [22:0] FULL_SCALE = 23'h7F_FFFF;
  // Constant-power pan law, cos(k*pi/16); entry 4 is -3 dB
  localparam logic [15:0] PAN_COS [9] = '{16'h7FFF, 16'h7D8A, 16'h7641, 16'h6A6D,
    16'h5A82, 16'h471D, 16'h30FB, 16'h18F9, 16'h0000};
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFRESH_MS = 500;
  localparam int REFRESH_CYCLES_DEF = REFRESH_MS * 1000000 / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_MIX = 2'b01, ST_PUSH = 2'b11} mix_st_t;
  typedef logic [N_SRC-1:0][SW-1:0] src_frame_t;
  typedef logic [N_OUT-1:0][SW-1:0] out_frame_t;
  typedef logic [N_IN-1:0][SW-1:0] rec_frame_t;
endpackage

// File: audio_matrix_mixer.sv
// Purpose: 22-source by 12-output routing matrix with pan, mute, solo, trim and metering.
// Assumes: One sample frame per i_frame_valid handshake; AHB-Lite register slave.
// Notes: One sequential MAC pass of 264 cycles per frame.
// Behaviour
// - Accept 10 inputs and 12 playbacks; route any to any of 12 outputs.
// - Six independent stereo submixes, one per output pair, own gains each.
// - Record path carries inputs unchanged unless loopback replaces a pair.
// - Peak and RMS meter for every input, playback and output channel.
// - Source meters tap pre-gain; output meters tap the final mixed signal.
// - Pan splits a mono source left/right, -3 dB each side at centre.
// - Level readout refreshed twice a second, peak or RMS, with overload flag.
// - Peak detector has zero attack; one full-scale sample shows full scale.
// - Overs shown; hold time, over criterion and RMS reference configurable.
// - Gain exists per routing, one per source and output channel.
// - Sources switch mono or stereo per pair; outputs are always stereo pairs.
// - Each input and playback channel has its own mute and solo.
// - Routing with gain minus infinity (zero) is inactive, contributes nothing.
// - Trim scales all active routings of a source; shows highest routing gain.
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Stream FIFO
// ------------------------------------------------------------------
module mix_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("mix_fifo depth must be a power of two, at least 2");
  end
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic nonempty;
  } fifo_st_t;
  fifo_st_t r;
  fifo_st_t next_r;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign push = i_valid && !r.full;
  assign pop = r.nonempty && i_ready;
  assign o_ready = !r.full;
  assign o_valid = r.nonempty;
  assign o_data = mem[r.rp[AW-1:0]];

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.wp = r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = r.rp + 1'b1;
    end
    next_r.full = (next_r.wp[AW-1:0] == next_r.rp[AW-1:0]) && (next_r.wp[AW] != next_r.rp[AW]);
    next_r.nonempty = next_r.wp != next_r.rp;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[r.wp[AW-1:0]] <= i_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// Mixer top
// ------------------------------------------------------------------
module audio_matrix_mixer
  import mixer_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYCLES_DEF
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_frame_valid,
  input wire src_frame_t i_src_frame,
  output logic o_frame_ready,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output out_frame_t o_out_frame,
  output logic o_rec_valid,
  output rec_frame_t o_rec_frame
);
  if (REFRESH_CYCLES < 2) begin : g_chk
    $error("REFRESH_CYCLES must be at least 2");
  end

  typedef struct packed {
    mix_st_t st;
    logic in_rdy;
    logic [3:0] o;
    logic [4:0] s;
    logic signed [31:0] acc;
    src_frame_t src;
    out_frame_t mix;
    logic rms_sel;
    logic [N_SRC/2-1:0] stereo;
    logic [N_SRC-1:0] mute;
    logic [N_SRC-1:0] solo;
    logic [N_SRC-1:0] trim_en;
    logic [N_IN/2-1:0] loop;
    logic [15:0] hold_time;
    logic [3:0] over_cnt;
    logic [31:0] rms_ref;
    logic [N_SRC-1:0][3:0] pan;
    logic [N_SRC-1:0][GW-1:0] trim;
    logic [N_SRC-1:0][GW-1:0] disp;
    logic [N_MTR-1:0][22:0] peak;
    logic [N_MTR-1:0][15:0] hold;
    logic [N_MTR-1:0][31:0] ms;
    logic [N_MTR-1:0][3:0] run;
    logic [N_MTR-1:0] overload_flag;
    logic [N_MTR-1:0][25:0] readout;
    logic [31:0] refresh;
    logic dp_wr;
    logic [12:0] dp_addr;
    logic [31:0] hrdata;
    logic rec_valid;
    rec_frame_t rec;
  } core_t;

  core_t r;
  core_t next_r;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [GW-1:0] gain_mem [N_OUT*32];
  logic fifo_rdy;
  logic accept;
  logic push_hs;
  logic tick;
  logic ap;
  logic last;
  logic [GW-1:0] g;
  logic [GW-1:0] coef;
  logic [GW-1:0] tfac;
  logic [GW-1:0] eff;
  logic pass;
  logic active;
  logic [3:0] pidx;
  logic signed [63:0] t1;
  logic signed [63:0] t2;
  logic signed [63:0] t3;
  logic signed [31:0] term;
  logic signed [31:0] sum;
  logic gain_wr;
  logic [8:0] gain_widx;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign accept = i_frame_valid && r.in_rdy;
  assign push_hs = (r.st == ST_PUSH) && fifo_rdy;
  assign tick = r.refresh == 32'(REFRESH_CYCLES - 1);
  assign ap = i_hsel && i_htrans[1] && i_hready;
  assign last = (r.s == 5'(N_SRC - 1));

  // ----------------------------------------------------------------
  // One routing term per cycle
  // ----------------------------------------------------------------
  always_comb begin
    g = gain_mem[{r.o, r.s}];
    pass = !r.mute[r.s] && (r.solo == '0 || r.solo[r.s]);
    active = pass && (g != '0);
    pidx = (r.pan[r.s] > PAN_MAX) ? PAN_MAX : r.pan[r.s];
    if (r.stereo[r.s[4:1]]) begin
      coef = (r.s[0] == r.o[0]) ? GAIN_UNITY : '0;
    end else begin
      coef = r.o[0] ? PAN_COS[PAN_MAX - pidx] : PAN_COS[pidx];
    end
    tfac = r.trim_en[r.s] ? r.trim[r.s] : GAIN_UNITY;
    t1 = ($signed({{40{r.src[r.s][SW-1]}}, r.src[r.s]}) * $signed({48'h0000_0000_0000, g})) >>> 15;
    t2 = (t1 * $signed({48'h0000_0000_0000, coef})) >>> 15;
    t3 = (t2 * $signed({48'h0000_0000_0000, tfac})) >>> 15;
    term = active ? t3[31:0] : '0;
    sum = (r.s == '0) ? term : r.acc + term;
    eff = 16'((32'(g) * 32'(tfac)) >> 15);
  end

  function automatic logic [SW-1:0] sat24(input logic signed [31:0] v);
    if (v > 32'sh007F_FFFF) begin
      return 24'h7F_FFFF;
    end else if (v < -32'sh0080_0000) begin
      return 24'h80_0000;
    end
    return v[SW-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Per-channel meters
  // ----------------------------------------------------------------
  logic [SW-1:0] msmp [N_MTR];
  logic mstb [N_MTR];
  logic [22:0] m_pk [N_MTR];
  logic [15:0] m_hold [N_MTR];
  logic [31:0] m_ms [N_MTR];
  logic [3:0] m_run [N_MTR];
  logic m_set [N_MTR];

  for (genvar c = 0; c < N_MTR; c++) begin : g_mtr
    logic [SW-1:0] a;
    logic [22:0] mag;
    logic full;
    logic [45:0] sq;
    if (c < N_SRC) begin : g_src
      assign msmp[c] = i_src_frame[c];
      assign mstb[c] = accept;
    end else begin : g_out
      assign msmp[c] = r.mix[c-N_SRC];
      assign mstb[c] = push_hs;
    end
    assign a = msmp[c][SW-1] ? (~msmp[c] + 1'b1) : msmp[c];
    assign full = a >= {1'b0, FULL_SCALE};
    assign mag = full ? FULL_SCALE : a[22:0];
    assign sq = 46'(mag) * 46'(mag);
    assign m_ms[c] = r.ms[c] - (r.ms[c] >> RMS_SHIFT) + (sq[45:14] >> RMS_SHIFT);
    always_comb begin
      if (mag >= r.peak[c]) begin
        m_pk[c] = mag;
        m_hold[c] = r.hold_time;
      end else if (r.hold[c] != '0) begin
        m_pk[c] = r.peak[c];
        m_hold[c] = r.hold[c] - 1'b1;
      end else begin
        m_pk[c] = r.peak[c] - (r.peak[c] >> 4);
        m_hold[c] = '0;
      end
      m_run[c] = full ? ((r.run[c] == 4'hF) ? 4'hF : r.run[c] + 1'b1) : '0;
      m_set[c] = mstb[c] && full && ({1'b0, m_run[c]} >= {1'b0, r.over_cnt});
    end
  end

  // ----------------------------------------------------------------
  // Bus read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd(input core_t q, input logic [12:0] a, input logic [GW-1:0] gv);
    logic [12:0] off;
    off = '0;
    rd = '0;
    unique case (a)
      A_MODE: rd = {31'h0, q.rms_sel};
      A_STEREO: rd = 32'(q.stereo);
      A_MUTE: rd = 32'(q.mute);
      A_SOLO: rd = 32'(q.solo);
      A_TRIM_EN: rd = 32'(q.trim_en);
      A_LOOP: rd = 32'(q.loop);
      A_HOLD: rd = 32'(q.hold_time);
      A_OVER: rd = 32'(q.over_cnt);
      A_RMS_REF: rd = q.rms_ref;
      A_STATUS: rd = {29'h0, q.in_rdy, q.st};
      default: begin
        if (a >= A_PAN_BASE && a < A_PAN_BASE + 13'(4 * N_SRC)) begin
          off = a - A_PAN_BASE;
          rd = 32'(q.pan[off[6:2]]);
        end else if (a >= A_TRIM_BASE && a < A_TRIM_BASE + 13'(4 * N_SRC)) begin
          off = a - A_TRIM_BASE;
          rd = 32'(q.disp[off[6:2]]);
        end else if (a >= A_METER_BASE && a < A_METER_BASE + 13'(4 * N_MTR)) begin
          off = a - A_METER_BASE;
          rd = 32'(q.readout[off[7:2]]);
        end else if (a[12] && !a[11] && a[10:7] < 4'(N_OUT) && a[6:2] < 5'(N_SRC)) begin
          rd = 32'(gv);
        end
      end
    endcase
  endfunction

  assign gain_widx = r.dp_addr[10:2];
  assign gain_wr = r.dp_wr && r.dp_addr[12] && r.dp_addr[11] == 1'b0
    && r.dp_addr[10:7] < 4'(N_OUT) && r.dp_addr[6:2] < 5'(N_SRC);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [12:0] off;
    off = '0;
    next_r = r;
    next_r.rec_valid = 1'b0;
    next_r.refresh = tick ? '0 : r.refresh + 1'b1;
    // Bus address phase, zero wait states
    next_r.dp_wr = ap && i_hwrite && (i_haddr[31:13] == '0);
    next_r.dp_addr = i_haddr[12:0];
    if (ap && !i_hwrite) begin
      next_r.hrdata = (i_haddr[31:13] == '0) ? rd(r, i_haddr[12:0], gain_mem[i_haddr[10:2]]) : '0;
    end
    // Bus data phase
    if (r.dp_wr) begin
      unique case (r.dp_addr)
        A_MODE: next_r.rms_sel = i_hwdata[0];
        A_STEREO: next_r.stereo = i_hwdata[N_SRC/2-1:0];
        A_MUTE: next_r.mute = i_hwdata[N_SRC-1:0];
        A_SOLO: next_r.solo = i_hwdata[N_SRC-1:0];
        A_TRIM_EN: next_r.trim_en = i_hwdata[N_SRC-1:0];
        A_LOOP: next_r.loop = i_hwdata[N_IN/2-1:0];
        A_HOLD: next_r.hold_time = i_hwdata[15:0];
        A_OVER: next_r.over_cnt = i_hwdata[3:0];
        A_RMS_REF: next_r.rms_ref = i_hwdata;
        default: begin
          if (r.dp_addr >= A_PAN_BASE && r.dp_addr < A_PAN_BASE + 13'(4 * N_SRC)) begin
            off = r.dp_addr - A_PAN_BASE;
            next_r.pan[off[6:2]] = i_hwdata[3:0];
          end else if (r.dp_addr >= A_TRIM_BASE && r.dp_addr < A_TRIM_BASE + 13'(4 * N_SRC)) begin
            off = r.dp_addr - A_TRIM_BASE;
            next_r.trim[off[6:2]] = i_hwdata[GW-1:0];
          end
        end
      endcase
    end
    // Mixing sequence
    unique case (r.st)
      ST_IDLE: begin
        if (accept) begin
          next_r.src = i_src_frame;
          next_r.st = ST_MIX;
          next_r.in_rdy = 1'b0;
          next_r.o = '0;
          next_r.s = '0;
        end
      end
      ST_MIX: begin
        next_r.acc = sum;
        if (g != '0) begin
          if (r.o == '0 || eff > r.disp[r.s]) begin
            next_r.disp[r.s] = eff;
          end
        end else if (r.o == '0) begin
          next_r.disp[r.s] = '0;
        end
        next_r.s = last ? '0 : r.s + 1'b1;
        if (last) begin
          next_r.mix[r.o] = sat24(sum);
          next_r.o = r.o + 1'b1;
          if (r.o == 4'(N_OUT - 1)) begin
            next_r.st = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        if (fifo_rdy) begin
          next_r.st = ST_IDLE;
          next_r.in_rdy = 1'b1;
          next_r.rec_valid = 1'b1;
          for (int i = 0; i < N_IN; i++) begin
            next_r.rec[i] = r.loop[i/2] ? r.mix[i] : r.src[i];
          end
        end
      end
      default: begin
        next_r.st = ST_IDLE;
        next_r.in_rdy = 1'b1;
      end
    endcase
    // Meters and readout
    for (int c = 0; c < N_MTR; c++) begin
      if (mstb[c]) begin
        next_r.peak[c] = m_pk[c];
        next_r.hold[c] = m_hold[c];
        next_r.ms[c] = m_ms[c];
        next_r.run[c] = m_run[c];
      end
      if (tick) begin
        next_r.readout[c] = {r.ms[c] >= r.rms_ref, r.overload_flag[c] || m_set[c],
          r.rms_sel ? r.ms[c][31:8] : {1'b0, r.peak[c]}};
      end
      // New over wins over the refresh clear
      next_r.overload_flag[c] = (r.overload_flag[c] && !tick) || m_set[c];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.in_rdy <= 1'b1;
      r.hold_time <= HOLD_RST;
      r.over_cnt <= OVER_RST;
      r.rms_ref <= RMS_REF_RST;
      r.pan <= {N_SRC{PAN_CENTRE}};
      r.trim <= {N_SRC{GAIN_UNITY}};
    end else begin
      r <= next_r;
    end
  end

  // Gains reset to minus infinity so no routing is live until set
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_OUT * 32; i++) begin
        gain_mem[i] <= '0;
      end
    end else if (gain_wr) begin
      gain_mem[gain_widx] <= i_hwdata[GW-1:0];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  assign o_hrdata = r.hrdata;
  assign o_frame_ready = r.in_rdy;
  assign o_rec_valid = r.rec_valid;
  assign o_rec_frame = r.rec;

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  mix_fifo #(.W(N_OUT * SW), .D(FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_valid(r.st == ST_PUSH),
    .o_ready(fifo_rdy),
    .i_data(r.mix),
    .o_valid(o_out_valid),
    .i_ready(i_out_ready),
    .o_data(o_out_frame)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rec_plain;
    @(posedge i_mclk) disable iff (!rst_n) o_rec_valid && !r.loop[0] |-> o_rec_frame[0] == r.src[0];
  endproperty
  a_rec_plain: assert property (p_rec_plain) else $error("record channel altered");
  property p_zero_attack;
    @(posedge i_mclk) disable iff (!rst_n)
      accept && i_src_frame[0] == 24'h7F_FFFF |=> r.peak[0] == FULL_SCALE;
  endproperty
  a_zero_attack: assert property (p_zero_attack) else $error("peak missed full scale");
  property p_out_meter;
    @(posedge i_mclk) disable iff (!rst_n)
      push_hs && (r.mix[0] == 24'h7F_FFFF || r.mix[0] == 24'h80_0000)
        |=> r.peak[N_SRC] == FULL_SCALE;
  endproperty
  a_out_meter: assert property (p_out_meter) else $error("output meter not post gain");
  property p_mute;
    @(posedge i_mclk) disable iff (!rst_n) r.st == ST_MIX && r.mute[r.s] |-> term == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("muted source reached mix");
  property p_inactive;
    @(posedge i_mclk) disable iff (!rst_n) r.st == ST_MIX && g == '0 |-> term == '0;
  endproperty
  a_inactive: assert property (p_inactive) else $error("zero gain routing contributed");
  property p_centre;
    @(posedge i_mclk) disable iff (!rst_n)
      !r.stereo[r.s[4:1]] && r.pan[r.s] == PAN_CENTRE |-> coef == 16'h5A82;
  endproperty
  a_centre: assert property (p_centre) else $error("centre pan not -3 dB");
  property p_stereo;
    @(posedge i_mclk) disable iff (!rst_n) r.stereo[r.s[4:1]] && r.s[0] != r.o[0] |-> coef == '0;
  endproperty
  a_stereo: assert property (p_stereo) else $error("stereo source crossed sides");
  property p_pass_len;
    @(posedge i_mclk) disable iff (!rst_n) accept |-> ##265 r.st == ST_PUSH;
  endproperty
  a_pass_len: assert property (p_pass_len) else $error("mix pass length wrong");
  property p_refresh;
    @(posedge i_mclk) disable iff (!rst_n)
      tick |=> r.readout[0][24] == $past(r.overload_flag[0] || m_set[0]);
  endproperty
  a_refresh: assert property (p_refresh) else $error("readout overload wrong");
  property p_over;
    @(posedge i_mclk) disable iff (!rst_n) m_set[0] |=> r.overload_flag[0];
  endproperty
  a_over: assert property (p_over) else $error("over not flagged");
  property p_trim_max;
    @(posedge i_mclk) disable iff (!rst_n)
      r.st == ST_MIX && g != '0 |=> r.disp[$past(r.s)] >= $past(eff);
  endproperty
  a_trim_max: assert property (p_trim_max) else $error("trim display below gain");
  property p_gain_wr;
    @(posedge i_mclk) disable iff (!rst_n) gain_wr |=> gain_mem[$past(gain_widx)] == $past(i_hwdata[15:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("routing gain not stored");
  c_frame: cover property (@(posedge i_mclk) disable iff (!rst_n) accept ##266 o_rec_valid);
  c_backpressure: cover property (@(posedge i_mclk) disable iff (!rst_n) r.st == ST_PUSH && !fifo_rdy);
  c_overload: cover property (@(posedge i_mclk) disable iff (!rst_n) tick && r.overload_flag != '0);
endmodule

// File: mix_sink.sv
// Purpose: Far-side sink for mixed output frames.
// Assumes: Stall input holds ready low.
// Notes: Keeps the last frame and a frame count.
`timescale 1ns/1ns
module mix_sink
  import mixer_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire out_frame_t i_frame,
  output logic o_ready = 1'b0,
  output out_frame_t o_last,
  output int o_count = 0
);
  always @(posedge i_mclk) begin
    if (o_ready && i_valid) begin
      o_last <= i_frame;
      o_count <= o_count + 1;
    end
    o_ready <= !i_stall;
  end
endmodule

// File: test_audio_matrix_mixer.sv
// Purpose: Self-checking bench for the routing matrix.
// Assumes: AHB master waits on hready; sink model drains outputs.
// Notes: Short refresh count keeps the run brief.
`timescale 1ns/1ns
module test_audio_matrix_mixer;
  import mixer_pkg::*;
  logic i_mclk = 0, i_nrst = 0, hsel = 0, hwr = 0, fv = 0, stall = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
  logic hrdy, hresp, rdy, ov, orv, srdy;
  src_frame_t src = '0;
  out_frame_t of, sf;
  rec_frame_t rf;
  int fails = 0, tests_run = 0, cnt, recs = 0;
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (orv === 1'b1) begin
      recs <= recs + 1;
    end
  end
  audio_matrix_mixer #(.REFRESH_CYCLES(64)) i_audio_matrix_mixer (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_frame_valid(fv), .i_src_frame(src),
    .o_frame_ready(rdy), .o_out_valid(ov), .i_out_ready(srdy), .o_out_frame(of),
    .o_rec_valid(orv), .o_rec_frame(rf));
  mix_sink i_mix_sink (.i_mclk(i_mclk), .i_stall(stall), .i_valid(ov), .i_frame(of),
    .o_ready(srdy), .o_last(sf), .o_count(cnt));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Checked at negedge so the edge's own updates have landed
  task automatic wt(input bit fr);
    int n = 0;
    @(negedge i_mclk);
    while ((fr ? rdy : hrdy) !== 1'b1) begin
      n++;
      if (n > 3000) begin
        fails++;
        close_out;
      end
      @(negedge i_mclk);
    end
    @(posedge i_mclk);
  endtask
  task automatic wcnt(input int t);
    int n = 0;
    while (cnt < t) begin
      @(posedge i_mclk);
      n++;
      if (n > 3000) begin
        fails++;
        close_out;
      end
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwr <= w;
    haddr <= a;
    wt(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(0);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, '0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  function automatic logic [31:0] ga(input int o, input int s);
    return 32'(A_GAIN_BASE) + 32'(4 * (o * 32 + s));
  endfunction
  task automatic send(input src_frame_t f);
    src <= f;
    fv <= 1'b1;
    wt(1);
    fv <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic run(input src_frame_t f);
    int c0;
    c0 = cnt;
    send(f);
    wcnt(c0 + 1);
    @(posedge i_mclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk(32'(A_HOLD), 32'h0000_4000);
    rchk(32'(A_OVER), 32'h0000_0003);
    rchk(32'(A_RMS_REF), RMS_REF_RST);
    rchk(32'(A_PAN_BASE) + 32'h0000_0004, 32'h0000_0004);
    rchk(32'h0000_2000, 32'h0000_0000);
    xfer(1'b1, 32'(A_HOLD), 32'h0000_0010);
    rchk(32'(A_HOLD), 32'h0000_0010);
    xfer(1'b1, ga(11, 21), 32'h0000_1234);
    rchk(ga(11, 21), 32'h0000_1234);
  endtask
  task automatic t_mix;
    src_frame_t f;
    f = '0;
    f[0] = 24'h10_0000;
    f[1] = 24'h12_3456;
    f[2] = 24'h00_0200;
    f[9] = 24'h05_0505;
    f[21] = 24'h00_7777;
    // Pairs 0 and 1 stereo: unity, no pan table involved
    xfer(1'b1, 32'(A_STEREO), 32'h0000_0003);
    xfer(1'b1, ga(0, 0), 32'h0000_8000);
    xfer(1'b1, ga(0, 2), 32'h0000_8000);
    xfer(1'b1, ga(2, 0), 32'h0000_4000);
    run(f);
    rchk(32'(A_TRIM_BASE), 32'h0000_8000);
    chk(32'(sf[0]), 32'h0010_0200);
    chk(32'(sf[1]), 32'h0000_0000);
    chk(32'(sf[2]), 32'h0008_0000);
    chk(32'(rf[9]), 32'h0005_0505);
    xfer(1'b1, 32'(A_MUTE), 32'h0000_0004);
    run(f);
    chk(32'(sf[0]), 32'h0010_0000);
    xfer(1'b1, 32'(A_MUTE), 32'h0000_0000);
    xfer(1'b1, 32'(A_SOLO), 32'h0000_0004);
    run(f);
    chk(32'(sf[0]), 32'h0000_0200);
    xfer(1'b1, 32'(A_SOLO), 32'h0000_0000);
    // Trim halves source 0 everywhere; loopback records output pair 0
    xfer(1'b1, 32'(A_TRIM_EN), 32'h0000_0001);
    xfer(1'b1, 32'(A_TRIM_BASE), 32'h0000_4000);
    xfer(1'b1, 32'(A_LOOP), 32'h0000_0001);
    run(f);
    chk(32'(sf[0]), 32'h0008_0200);
    chk(32'(sf[2]), 32'h0004_0000);
    chk(32'(rf[0]), 32'h0008_0200);
    rchk(32'(A_TRIM_BASE), 32'h0000_4000);
    xfer(1'b1, 32'(A_TRIM_EN), 32'h0000_0000);
    xfer(1'b1, 32'(A_LOOP), 32'h0000_0000);
    f[0] = 24'h7F_FFFF;
    f[2] = 24'h7F_FFFF;
    run(f);
    chk(32'(sf[0]), 32'h007F_FFFF);
    // Readout only refreshes on its tick
    repeat (64) @(posedge i_mclk);
    xfer(1'b0, 32'(A_METER_BASE), '0);
    chk({8'h00, rd[23:0]}, 32'h007F_FFFF);
    xfer(1'b0, 32'(A_METER_BASE) + 32'h0000_0060, '0);
    chk({8'h00, rd[23:0]}, 32'h003F_FFFF);
  endtask
  // Sink stalls: four frames fill the FIFO, the fifth stays in the mixer
  task automatic t_fifo;
    int c0;
    c0 = cnt;
    stall <= 1'b1;
    repeat (5) send('0);
    repeat (300) @(posedge i_mclk);
    chk({30'h0, ov, rdy}, 32'h0000_0002);
    stall <= 1'b0;
    wcnt(c0 + 5);
    repeat (4) @(posedge i_mclk);
    chk({30'h0, ov, rdy}, 32'h0000_0001);
    chk(recs, 32'h0000_000A);
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_regs;
    t_mix;
    t_fifo;
    close_out;
  end
endmodule
